// ===== design/psc_cfg.svh
// Summary of operation
// - ten-bit program counter holds next address
// - non-branch instruction advances counter by length
// - every taken jump into mounted steps loads operand address
// - call saves counter plus length and loads target
// - return reloads counter from saved address
// - reset forces program counter to zero
// - call increments depth, return decrements it
// - reset clears stack depth to zero
// - stack overflow or underflow forces system reset
// - stack depth changes only by call/return/reset
// - ten-bit return register, low byte shared
// - return register keeps value after return
// - reset leaves return register untouched
// - shared word access spoils upper two bits
// - ten-bit program words addressed by counter
// - steps 3ea to 3ff reserved for test
// - unmounted or test area redirects to zero
// - low reset pin resets the processor
// - power-on clear drives reset pin low
`ifndef PSC_CFG_SVH
`define PSC_CFG_SVH
`define PSC_PC_W       10
`define PSC_RA_LO_W    8
`define PSC_ROM_DEPTH  1024
`define PSC_ROM_STEPS  10'h3ea
`define PSC_TEST_BASE  10'h3ea
`define PSC_RESET_PC   10'h000
`define PSC_DEPTH_RST  1'h0
`define PSC_RA_HI_FILL 2'h0
`endif

// ===== design/psc_pkg.sv
package psc_pkg;
  typedef enum logic [1:0] {
    PSC_OP_SEQ  = 2'b00,
    PSC_OP_JUMP = 2'b01,
    PSC_OP_CALL = 2'b10,
    PSC_OP_RET  = 2'b11
  } psc_op_t;
  typedef enum logic [2:0] {
    PSC_JUMP_ALWAYS      = 3'b000,
    PSC_JUMP_IF_CARRY    = 3'b001,
    PSC_JUMP_IF_NO_CARRY = 3'b010,
    PSC_JUMP_IF_FLAG     = 3'b011,
    PSC_JUMP_IF_NO_FLAG  = 3'b100
  } psc_cond_t;
  typedef struct packed {
    psc_op_t     op;
    psc_cond_t   cond;
    logic [1:0]  len;
    logic [9:0]  target;
  } psc_instr_t;
endpackage

// ===== design/psc_top.sv
`timescale 1ns/10ps
`include "psc_cfg.svh"
module psc_top (
  input  wire logic                CLOCK,
  input  wire logic                RST_N,
  input  wire logic                POC_ACTIVE,
  input  wire logic                INSTR_VALID,
  input  wire psc_pkg::psc_instr_t INSTR,
  input  wire logic                CARRY_FLAG,
  input  wire logic                STATUS_FLAG,
  input  wire logic                DW_WE,
  input  wire logic                DW_RE,
  input  wire logic [7:0]          DW_WDATA,
  input  wire logic                PROG_WE,
  input  wire logic [9:0]          PROG_WADDR,
  input  wire logic [9:0]          PROG_WDATA,
  output logic [9:0]               PROGRAM_COUNTER,
  output logic [9:0]               INSTR_WORD,
  output logic                     STACK_DEPTH,
  output logic [9:0]               RETURN_ADDRESS_REG,
  output logic [7:0]               SHARED_LAST_DATA_WORD,
  output logic                     STACK_FAULT,
  output logic                     CORE_RST,
  output logic                     RST_PIN_O,
  output logic                     RST_PIN_OE
);

  // true for unmounted area and test area alike
  function automatic logic bad_addr(input logic [9:0] a);
    bad_addr = (a >= `PSC_ROM_STEPS) || (a >= `PSC_TEST_BASE);
  endfunction

  function automatic logic [9:0] fold(input logic [9:0] a);
    fold = bad_addr(a) ? `PSC_RESET_PC : a;
  endfunction

  function automatic logic taken(input psc_pkg::psc_cond_t c,
                                 input logic cy,
                                 input logic f);
    unique case (c)
      psc_pkg::PSC_JUMP_ALWAYS:      taken = 1'b1;
      psc_pkg::PSC_JUMP_IF_CARRY:    taken = cy;
      psc_pkg::PSC_JUMP_IF_NO_CARRY: taken = !cy;
      psc_pkg::PSC_JUMP_IF_FLAG:     taken = f;
      psc_pkg::PSC_JUMP_IF_NO_FLAG:  taken = !f;
      default:                       taken = 1'b0;
    endcase
  endfunction

  logic [1:0]  rst_sync_ff;
  logic        rst_n;
  logic        poc_meta_ff;
  logic        poc_sync_ff;
  logic        oe_ff;
  logic [9:0]  pc_ff;
  logic [9:0]  nxt_pc;
  logic [9:0]  seq_pc;
  logic        depth_ff;
  logic        nxt_depth;
  logic        fault_now;
  logic        fault_ff;
  logic        sys_rst_ff;
  logic [9:0]  ra_ff;
  logic [9:0]  word_ff;
  logic        is_call;
  logic        is_ret;
  logic [9:0]  rom [0:`PSC_ROM_DEPTH-1];

  // reset pin released through two flip-flops
  always_ff @(posedge CLOCK or negedge RST_N) begin
    if (!RST_N) begin
      rst_sync_ff <= 2'h0;
    end else begin
      rst_sync_ff <= {rst_sync_ff[0], 1'b1};
    end
  end
  assign rst_n = rst_sync_ff[1];

  // no reset here on purpose: the pin we drive low would
  // otherwise clear the very request that drives it
  always_ff @(posedge CLOCK) begin
    poc_meta_ff <= POC_ACTIVE;
    poc_sync_ff <= poc_meta_ff;
  end

  always_ff @(posedge CLOCK) begin
    oe_ff <= poc_sync_ff;
  end

  assign is_call = INSTR_VALID && (INSTR.op == psc_pkg::PSC_OP_CALL);
  assign is_ret  = INSTR_VALID && (INSTR.op == psc_pkg::PSC_OP_RET);
  assign seq_pc  = pc_ff + {8'h00, INSTR.len};

  assign fault_now = (is_call && depth_ff)
                  || (is_ret && !depth_ff);

  always_comb begin
    nxt_pc    = pc_ff;
    nxt_depth = depth_ff;
    if (INSTR_VALID) begin
      unique case (INSTR.op)
        psc_pkg::PSC_OP_SEQ: begin
          nxt_pc = fold(seq_pc);
        end
        psc_pkg::PSC_OP_JUMP: begin
          if (taken(INSTR.cond, CARRY_FLAG, STATUS_FLAG)) begin
            nxt_pc = fold(INSTR.target);
          end else begin
            // untaken jump falls through like a plain step
            nxt_pc = fold(seq_pc);
          end
        end
        psc_pkg::PSC_OP_CALL: begin
          nxt_pc    = fold(INSTR.target);
          nxt_depth = 1'b1;
        end
        psc_pkg::PSC_OP_RET: begin
          nxt_pc    = fold(ra_ff);
          nxt_depth = 1'b0;
        end
      endcase
    end
  end

  // depth has no other writer: only call, return, reset
  always_ff @(posedge CLOCK or negedge RST_N) begin
    if (!RST_N) begin
      depth_ff <= `PSC_DEPTH_RST;
    end else if (!rst_n || poc_sync_ff || fault_now) begin
      depth_ff <= `PSC_DEPTH_RST;
    end else begin
      depth_ff <= nxt_depth;
    end
  end

  always_ff @(posedge CLOCK or negedge RST_N) begin
    if (!RST_N) begin
      pc_ff <= `PSC_RESET_PC;
    end else if (!rst_n || poc_sync_ff || fault_now) begin
      pc_ff <= `PSC_RESET_PC;
    end else begin
      pc_ff <= nxt_pc;
    end
  end

  always_ff @(posedge CLOCK or negedge RST_N) begin
    if (!RST_N) begin
      fault_ff   <= 1'b0;
      sys_rst_ff <= 1'b1;
    end else begin
      // a fault's internal reset lasts one cycle; the pin stays quiet
      fault_ff   <= fault_now && rst_n && !poc_sync_ff;
      sys_rst_ff <= !rst_n || poc_sync_ff || fault_now;
    end
  end

  // return register is storage only: no reset, so a reset keeps
  // the saved address and power-up leaves it unknown
  // a call beats a write, and a write beats a read
  always_ff @(posedge CLOCK) begin
    if (is_call && !depth_ff && rst_n && !poc_sync_ff) begin
      ra_ff <= fold(seq_pc);
    end else if (DW_WE) begin
      ra_ff <= {`PSC_RA_HI_FILL, DW_WDATA};
    end else if (DW_RE) begin
      ra_ff[9:8] <= `PSC_RA_HI_FILL;
    end
  end

  // loading of the program store; reserved steps stay unused
  // the test steps are never written, so they read unknown
  always_ff @(posedge CLOCK) begin
    if (PROG_WE && !bad_addr(PROG_WADDR)) begin
      rom[PROG_WADDR] <= PROG_WDATA;
    end
  end

  always_ff @(posedge CLOCK) begin
    word_ff <= rom[pc_ff];
  end

  assign PROGRAM_COUNTER       = pc_ff;
  assign INSTR_WORD            = word_ff;
  assign STACK_DEPTH           = depth_ff;
  assign RETURN_ADDRESS_REG    = ra_ff;
  assign SHARED_LAST_DATA_WORD = ra_ff[7:0];
  assign STACK_FAULT           = fault_ff;
  assign CORE_RST              = sys_rst_ff;
  assign RST_PIN_O             = 1'b0;
  assign RST_PIN_OE            = oe_ff;

  default clocking cb @(posedge CLOCK);
  endclocking
  default disable iff (!rst_n || poc_sync_ff);

  pc_advance_a:
    assert property (
      INSTR_VALID && INSTR.op == psc_pkg::PSC_OP_SEQ
      && !bad_addr(seq_pc)
      |=> pc_ff == $past(pc_ff) + {8'h00, $past(INSTR.len)})
    else $error("pc did not advance by instruction length");

  jump_load_a:
    assert property (
      INSTR_VALID && INSTR.op == psc_pkg::PSC_OP_JUMP
      && taken(INSTR.cond, CARRY_FLAG, STATUS_FLAG)
      && !bad_addr(INSTR.target)
      |=> pc_ff == $past(INSTR.target))
    else $error("taken jump did not load target");

  call_save_a:
    assert property (
      is_call && !depth_ff && !bad_addr(INSTR.target)
      && !bad_addr(seq_pc)
      |=> ra_ff == $past(seq_pc) && pc_ff == $past(INSTR.target))
    else $error("call did not save return and load target");

  ret_load_a:
    assert property (
      is_ret && depth_ff && !bad_addr(ra_ff)
      |=> pc_ff == $past(ra_ff) && !depth_ff)
    else $error("return did not restore saved address");

  depth_step_a:
    assert property (
      is_call && !depth_ff |=> depth_ff ##1 1'b1)
    else $error("call did not raise stack depth");

  stack_fault_a:
    assert property (
      fault_now |=> pc_ff == `PSC_RESET_PC && !depth_ff
      && STACK_FAULT && CORE_RST)
    else $error("stack fault did not reset sequencer");

  ra_keep_a:
    assert property (
      is_ret && depth_ff && !DW_WE && !DW_RE
      |=> $stable(ra_ff))
    else $error("return register changed on return");

  no_bad_pc_a:
    assert property (!bad_addr(pc_ff))
    else $error("pc sits in unmounted or test area");

  depth_hold_a:
    assert property (
      !INSTR_VALID |=> $stable(depth_ff))
    else $error("stack depth changed without call or return");

  spoil_hi_a:
    assert property (
      DW_RE && !is_call && !DW_WE
      |=> ra_ff[9:8] == `PSC_RA_HI_FILL
      && ra_ff[7:0] == $past(ra_ff[7:0]))
    else $error("shared word read handled wrongly");

  reset_pc_a:
    assert property (
      @(posedge CLOCK) $rose(rst_n) |-> pc_ff == `PSC_RESET_PC
      && !depth_ff)
    else $error("pc or depth not cleared by reset");

  poc_pin_a:
    assert property (
      @(posedge CLOCK) disable iff (1'b0)
      poc_sync_ff |=> RST_PIN_OE && !RST_PIN_O)
    else $error("reset pin not driven during power-on clear");

  // pc only moves on an instruction; resets are masked above
  hold_pc_a:
    assert property (!INSTR_VALID |=> $stable(pc_ff))
    else $error("pc moved without an instruction");

  jump_skip_a:
    assert property (
      INSTR_VALID && INSTR.op == psc_pkg::PSC_OP_JUMP
      && !taken(INSTR.cond, CARRY_FLAG, STATUS_FLAG)
      && !bad_addr(seq_pc)
      |=> pc_ff == $past(seq_pc))
    else $error("untaken jump did not step by length");

  // folding is what keeps the fetch out of the test steps
  seq_wrap_a:
    assert property (
      INSTR_VALID && INSTR.op == psc_pkg::PSC_OP_SEQ
      && bad_addr(seq_pc)
      |=> pc_ff == `PSC_RESET_PC)
    else $error("sequential step into bad area not folded");

  jump_fold_a:
    assert property (
      INSTR_VALID && INSTR.op == psc_pkg::PSC_OP_JUMP
      && taken(INSTR.cond, CARRY_FLAG, STATUS_FLAG)
      && bad_addr(INSTR.target)
      |=> pc_ff == `PSC_RESET_PC)
    else $error("jump into bad area not folded");

  ret_depth_a:
    assert property (
      is_ret && depth_ff |=> !depth_ff && !STACK_FAULT)
    else $error("return did not lower stack depth");

  // a refused call must not overwrite the live return address
  fault_keep_a:
    assert property (
      fault_now && !DW_WE && !DW_RE |=> $stable(ra_ff))
    else $error("stack fault changed return register");

  fault_clear_a:
    assert property (
      STACK_FAULT |-> pc_ff == `PSC_RESET_PC && !depth_ff)
    else $error("fault flag without cleared sequencer");

  core_rst_pc_a:
    assert property (CORE_RST |-> pc_ff == `PSC_RESET_PC)
    else $error("internal reset with pc away from zero");

  word_write_a:
    assert property (
      DW_WE && !is_call
      |=> ra_ff == {`PSC_RA_HI_FILL, $past(DW_WDATA)})
    else $error("shared word write not stored");

  poc_clear_a:
    assert property (
      @(posedge CLOCK) disable iff (!rst_n)
      poc_sync_ff |=> !depth_ff && pc_ff == `PSC_RESET_PC)
    else $error("power-on clear left pc or depth set");

  pin_release_a:
    assert property (
      @(posedge CLOCK) disable iff (1'b0)
      !poc_sync_ff |=> !RST_PIN_OE)
    else $error("reset pin still driven after power-on clear");

  call_ret_c:
    cover property (is_call ##[1:20] is_ret);

  overflow_c:
    cover property (is_call && depth_ff);

  underflow_c:
    cover property (is_ret && !depth_ff);

  wrap_c:
    cover property (INSTR_VALID && bad_addr(seq_pc)
                    && INSTR.op == psc_pkg::PSC_OP_SEQ);

  fault_recover_c:
    cover property (STACK_FAULT ##1 is_call);

endmodule // psc_top

// ===== verif/program_sequencer_call_stack_tb.sv
`timescale 1ns/10ps
module program_sequencer_call_stack_tb;
  logic                CLOCK, RST_N, POC_ACTIVE, INSTR_VALID;
  logic                CARRY_FLAG, STATUS_FLAG, DW_WE, DW_RE, PROG_WE;
  psc_pkg::psc_instr_t INSTR;
  logic [7:0]          DW_WDATA, SHARED_LAST_DATA_WORD;
  logic [9:0]          PROG_WADDR, PROG_WDATA, PROGRAM_COUNTER;
  logic [9:0]          INSTR_WORD, RETURN_ADDRESS_REG;
  logic                STACK_DEPTH, STACK_FAULT, CORE_RST;
  logic                RST_PIN_O, RST_PIN_OE;
  int                  err_total, checks_done, cyc, i;
  logic [9:0]          pc, ra, wr;
  logic                depth, ra_ok;

  psc_top DUT (.CLOCK(CLOCK), .RST_N(RST_N), .POC_ACTIVE(POC_ACTIVE),
    .INSTR_VALID(INSTR_VALID), .INSTR(INSTR), .CARRY_FLAG(CARRY_FLAG),
    .STATUS_FLAG(STATUS_FLAG), .DW_WE(DW_WE), .DW_RE(DW_RE),
    .DW_WDATA(DW_WDATA), .PROG_WE(PROG_WE), .PROG_WADDR(PROG_WADDR),
    .PROG_WDATA(PROG_WDATA), .PROGRAM_COUNTER(PROGRAM_COUNTER),
    .INSTR_WORD(INSTR_WORD), .STACK_DEPTH(STACK_DEPTH),
    .RETURN_ADDRESS_REG(RETURN_ADDRESS_REG),
    .SHARED_LAST_DATA_WORD(SHARED_LAST_DATA_WORD),
    .STACK_FAULT(STACK_FAULT), .CORE_RST(CORE_RST),
    .RST_PIN_O(RST_PIN_O), .RST_PIN_OE(RST_PIN_OE));

  initial CLOCK = 1'b0;
  always #5 CLOCK = ~CLOCK;

  task automatic end_sim();
    $display("checks %0d mismatches %0d", checks_done, err_total);
    if (err_total == 0 && checks_done > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask

  // a hang costs one mismatch and still reaches the report
  always @(posedge CLOCK) begin
    cyc++;
    if (cyc == 5000) begin
      err_total++;
      end_sim();
    end
  end

  task automatic chk(input logic [9:0] got, input logic [9:0] exp);
    checks_done++;
    if (got !== exp) begin
      err_total++;
      $display("unexpected at %0t got %h exp %h", $time, got, exp);
    end
  endtask

  function automatic logic [9:0] fold(input logic [9:0] a);
    return (a >= 10'h3ea) ? 10'h000 : a;
  endfunction

  function automatic logic taken(input logic [2:0] c, input logic cy, f);
    case (c)
      3'h0: return 1'b1;
      3'h1: return cy;
      3'h2: return !cy;
      3'h3: return f;
      3'h4: return !f;
      default: return 1'b0;
    endcase
  endfunction

  task automatic step(input psc_pkg::psc_op_t op, input logic [2:0] c,
                      input logic [1:0] len, input logic [9:0] tgt);
    logic cy, f, flt;
    cy = 1'($urandom);
    f = 1'($urandom);
    flt = 1'b0;
    @(posedge CLOCK);
    #1;
    INSTR_VALID = 1'b1;
    INSTR = '{op, psc_pkg::psc_cond_t'(c), len, tgt};
    CARRY_FLAG = cy;
    STATUS_FLAG = f;
    case (op)
      psc_pkg::PSC_OP_SEQ: pc = fold(pc + 10'(len));
      psc_pkg::PSC_OP_JUMP: pc = fold(taken(c, cy, f) ? tgt : pc + 10'(len));
      psc_pkg::PSC_OP_CALL: begin
        flt = depth;
        if (!depth) begin
          ra = fold(pc + 10'(len));
          ra_ok = 1'b1;
          depth = 1'b1;
          pc = fold(tgt);
        end
      end
      default: begin
        flt = !depth;
        depth = 1'b0;
        pc = flt ? 10'h000 : fold(ra);
      end
    endcase
    if (flt) begin
      pc = 10'h000;
      depth = 1'b0;
    end
    @(posedge CLOCK);
    #1;
    INSTR_VALID = 1'b0;
    chk(PROGRAM_COUNTER, pc);
    chk(10'(STACK_DEPTH), 10'(depth));
    chk(10'(STACK_FAULT), 10'(flt));
    if (flt) chk(10'(CORE_RST), 10'h001);
    if (ra_ok) chk(RETURN_ADDRESS_REG, ra);
    if (ra_ok) chk(10'(SHARED_LAST_DATA_WORD), 10'(ra[7:0]));
    // the internal reset after a fault must clear before the next fetch
    if (flt) repeat (2) @(posedge CLOCK);
  endtask

  task automatic dw(input logic we, input logic re, input logic [7:0] d);
    @(posedge CLOCK);
    #1;
    DW_WE = we;
    DW_RE = re;
    DW_WDATA = d;
    if (we) ra = {2'h0, d};
    else ra[9:8] = 2'h0;
    @(posedge CLOCK);
    #1;
    DW_WE = 1'b0;
    DW_RE = 1'b0;
    chk(RETURN_ADDRESS_REG, ra);
    chk(10'(SHARED_LAST_DATA_WORD), 10'(d & {8{we}} | ra[7:0]));
  endtask

  initial begin
    {RST_N, POC_ACTIVE, INSTR_VALID, CARRY_FLAG, STATUS_FLAG} = '0;
    {DW_WE, DW_RE, PROG_WE, DW_WDATA, PROG_WADDR, PROG_WDATA} = '0;
    INSTR = '0;
    {pc, ra, depth, ra_ok} = '0;
    wr = 10'($urandom(32248));
    repeat (20) @(posedge CLOCK);
    #1 RST_N = 1'b1; // key-return pins are not modelled here
    repeat (4) @(posedge CLOCK);
    #1;
    chk(PROGRAM_COUNTER, 10'h000);
    chk(10'(STACK_DEPTH), 10'h000);
    chk(10'(RST_PIN_OE), 10'h000);
    $display("test reset done");
    wr = 10'($urandom);
    PROG_WE = 1'b1;
    PROG_WADDR = 10'h005;
    PROG_WDATA = wr;
    @(posedge CLOCK);
    #1 PROG_WE = 1'b0;
    step(psc_pkg::PSC_OP_JUMP, 3'h0, 2'h1, 10'h005);
    @(posedge CLOCK);
    #1 chk(INSTR_WORD, wr);
    for (i = 0; i < 5; i++) step(psc_pkg::PSC_OP_JUMP, 3'(i), 2'h2, 10'h1a0);
    step(psc_pkg::PSC_OP_JUMP, 3'h0, 2'h1, 10'h3ea);
    step(psc_pkg::PSC_OP_JUMP, 3'h0, 2'h1, 10'h3e9);
    step(psc_pkg::PSC_OP_SEQ, 3'h0, 2'h1, 10'h000);
    $display("test jumps done");
    step(psc_pkg::PSC_OP_JUMP, 3'h0, 2'h1, 10'h3e0);
    step(psc_pkg::PSC_OP_CALL, 3'h0, 2'h2, 10'h2f0);
    step(psc_pkg::PSC_OP_RET, 3'h0, 2'h1, 10'h000);
    step(psc_pkg::PSC_OP_RET, 3'h0, 2'h1, 10'h000);
    step(psc_pkg::PSC_OP_CALL, 3'h0, 2'h2, 10'h3ff);
    step(psc_pkg::PSC_OP_CALL, 3'h0, 2'h2, 10'h044);
    $display("test stack done");
    dw(1'b0, 1'b1, 8'h00);
    dw(1'b1, 1'b0, 8'($urandom));
    step(psc_pkg::PSC_OP_CALL, 3'h0, 2'h1, 10'h100);
    @(posedge CLOCK);
    #1 RST_N = 1'b0;
    repeat (3) @(posedge CLOCK);
    #1 RST_N = 1'b1;
    {pc, depth} = '0;
    repeat (4) @(posedge CLOCK);
    #1;
    chk(PROGRAM_COUNTER, pc);
    chk(10'(STACK_DEPTH), 10'h000);
    chk(RETURN_ADDRESS_REG, ra);
    $display("test shared word and reset done");
    step(psc_pkg::PSC_OP_CALL, 3'h0, 2'h1, 10'h155);
    POC_ACTIVE = 1'b1;
    repeat (4) @(posedge CLOCK);
    #1;
    chk({RST_PIN_OE, RST_PIN_O, CORE_RST}, 10'h005);
    chk(PROGRAM_COUNTER, 10'h000);
    chk(10'(STACK_DEPTH), 10'h000);
    POC_ACTIVE = 1'b0;
    {pc, depth} = '0;
    repeat (5) @(posedge CLOCK);
    #1 chk({RST_PIN_OE, CORE_RST}, 10'h000);
    $display("test power-on clear done");
    for (i = 0; i < 60; i++)
      step(psc_pkg::psc_op_t'($urandom_range(3, 0)), 3'($urandom_range(4, 0)),
           2'($urandom_range(2, 1)), 10'($urandom_range(10'h3f0, 0)));
    $display("test random done");
    end_sim();
  end
endmodule // program_sequencer_call_stack_tb
